// ### logic/tlr_regs.vh
`ifndef TLR_REGS_VH
`define TLR_REGS_VH
// program memory geometry
`define TLR_PM_AW 12
`define TLR_PM_SMALL_TOP 12'h7ff
`define TLR_PM_LARGE_TOP 12'hfff
`define TLR_PM_ALIAS_BIT 11
`define TLR_PM_SPECIAL_TOP 12'h086
// nibble fields of a program byte
`define TLR_LO_NIB_MSB 3
`define TLR_HI_NIB_MSB 7
`define TLR_HI_NIB_LSB 4
// reset values
`define TLR_PTR_RST 12'h000
`define TLR_REG_RST 4'h0
// pointer operations on the in-page register
`define TLR_LOP_HOLD 2'h0
`define TLR_LOP_LOAD 2'h1
`define TLR_LOP_INC 2'h2
`define TLR_LOP_DEC 2'h3
`endif

// ### logic/tlr_rom.v
`include "tlr_regs.vh"
// program memory with registered read data
module tlr_rom (
  // clock
  input wire clk_sys,
  // read port
  input wire rd_en,
  input wire [11:0] rd_addr,
  output reg [7:0] rd_data_q,
  // load port used to fill contents
  input wire wr_en,
  input wire [11:0] wr_addr,
  input wire [7:0] wr_data
);
  reg [7:0] mem [0:4095];

  // no reset on the array or read register; contents come from the load port
  always @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en)
    begin
      rd_data_q <= mem[rd_addr];
    end
  end
endmodule // tlr_rom

// ### logic/tlr_lookup.v
// Notes on behaviour
// - low-nibble lookup loads bits 3..0 of the byte at the table pointer into acc_data.
// - high-nibble lookup loads bits 7..4 of the byte at the table pointer into acc_data.
// - the table pointer is twelve bits and reaches the whole program space.
// - addresses 000 to 086 hex are flagged as special-purpose locations.
// - the small variant holds 2048 bytes, the large variant 4096 bytes.
// - on the small variant address bit 11 is forced low, aliasing the upper half.
// - page and in-page registers are 4-bit and together form the ram pointer pair.
// - ram words sit in 16-word pages: page register picks page, in-page the word.
// - the in-page register post-increments or post-decrements after its transfer.
// - indirect port bit ops use the in-page register to choose the port bit.
`include "tlr_regs.vh"
module tlr_lookup #(
  parameter LARGE_VARIANT = 1
) (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // table pointer load
  input wire ptr_load,
  input wire [11:0] ptr_load_val,
  // lookup requests, one-cycle pulses
  input wire load_low_nibble_lookup,
  input wire load_high_nibble_lookup,
  // accumulator result
  output reg [3:0] acc_data_q,
  output reg acc_valid_q,
  output wire lookup_busy,
  output wire [11:0] table_pointer,
  output reg special_area_q,
  // ram pointer pair control
  input wire page_load,
  input wire [3:0] page_val,
  input wire [1:0] inpage_op,
  input wire [3:0] inpage_val,
  input wire ram_access,
  output wire [7:0] ram_addr,
  output wire ram_access_done,
  output wire [3:0] ram_pointer_pair_page,
  output wire [3:0] ram_pointer_pair_word,
  // indirect port bit select
  input wire indirect_port_bit_op,
  output reg [15:0] port_bit_sel,
  // rom fill port
  input wire rom_wr_en,
  input wire [11:0] rom_wr_addr,
  input wire [7:0] rom_wr_data
);
  localparam ST_IDLE = 2'h0;
  localparam ST_READ = 2'h1;
  localparam ST_DONE = 2'h2;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg high_q;
  reg [11:0] table_pointer_q;
  reg [3:0] page_q;
  reg [3:0] word_q;
  wire [7:0] rom_q;
  wire [11:0] rom_addr;
  wire start;

  // fold a raw address onto the fitted memory size
  function [11:0] fold_addr;
    input [11:0] a;
    begin
      fold_addr = a;
      if (LARGE_VARIANT == 0)
      begin
        fold_addr[`TLR_PM_ALIAS_BIT] = 1'b0;
      end
    end
  endfunction

  assign table_pointer = table_pointer_q;
  assign rom_addr = fold_addr(table_pointer_q);
  assign start = (state_q == ST_IDLE) & (load_low_nibble_lookup | load_high_nibble_lookup);
  assign lookup_busy = (state_q != ST_IDLE);

  tlr_rom u_rom (
    .clk_sys(clk_sys),
    .rd_en(start),
    .rd_addr(rom_addr),
    .rd_data_q(rom_q),
    .wr_en(rom_wr_en),
    .wr_addr(fold_addr(rom_wr_addr)),
    .wr_data(rom_wr_data)
  );

  // sequencer: idle, one cycle for the registered read, then result
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (start)
        begin
          state_d = ST_READ;
        end
      end
      ST_READ: state_d = ST_DONE;
      ST_DONE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // requests arriving while busy are dropped; the core issues one at a time
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      high_q <= 1'b0;
      table_pointer_q <= `TLR_PTR_RST;
      acc_data_q <= `TLR_REG_RST;
      acc_valid_q <= 1'b0;
      special_area_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      acc_valid_q <= 1'b0;
      if (start)
      begin
        high_q <= load_high_nibble_lookup & ~load_low_nibble_lookup;
        special_area_q <= (rom_addr <= `TLR_PM_SPECIAL_TOP);
      end
      if (state_q == ST_READ)
      begin
        acc_valid_q <= 1'b1;
        if (high_q)
        begin
          acc_data_q <= rom_q[`TLR_HI_NIB_MSB:`TLR_HI_NIB_LSB];
          table_pointer_q <= table_pointer_q + 12'h001;
        end
        else
        begin
          acc_data_q <= rom_q[`TLR_LO_NIB_MSB:0];
        end
      end
      else if (ptr_load & (state_q == ST_IDLE))
      begin
        table_pointer_q <= ptr_load_val;
      end
    end
  end

  // ram pointer pair; address uses current value, step lands after the access
  assign ram_addr = {page_q, word_q};
  assign ram_access_done = ram_access;
  assign ram_pointer_pair_page = page_q;
  assign ram_pointer_pair_word = word_q;

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      page_q <= `TLR_REG_RST;
      word_q <= `TLR_REG_RST;
    end
    else
    begin
      if (page_load)
      begin
        page_q <= page_val;
      end
      case (inpage_op)
        `TLR_LOP_LOAD: word_q <= inpage_val;
        `TLR_LOP_INC: word_q <= word_q + 4'h1;
        `TLR_LOP_DEC: word_q <= word_q - 4'h1;
        default: word_q <= word_q;
      endcase
    end
  end

  // one-hot port bit select from the in-page register
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      port_bit_sel <= 16'h0000;
    end
    else if (indirect_port_bit_op)
    begin
      port_bit_sel <= 16'h0001 << word_q;
    end
    else
    begin
      port_bit_sel <= 16'h0000;
    end
  end
endmodule // tlr_lookup

// ### dv/tlr_lookup_monitor.sv
module tlr_lookup_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // lookup side
  input wire logic ptr_load,
  input wire logic load_low_nibble_lookup,
  input wire logic load_high_nibble_lookup,
  input wire logic acc_valid_q,
  input wire logic lookup_busy,
  input wire logic [11:0] table_pointer,
  // ram pointer side
  input wire logic [1:0] inpage_op,
  input wire logic [7:0] ram_addr,
  input wire logic [3:0] ram_pointer_pair_page,
  input wire logic [3:0] ram_pointer_pair_word,
  input wire logic indirect_port_bit_op,
  input wire logic [15:0] port_bit_sel
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // a taken request; busy requests are dropped
  wire logic lo = load_low_nibble_lookup & ~lookup_busy & ~ptr_load;
  wire logic hi = load_high_nibble_lookup & ~load_low_nibble_lookup & ~lookup_busy & ~ptr_load;
  a_valid_two_later: assert property ((lo | hi) |-> ##2 acc_valid_q)
    else $error("result pulse late");
  a_busy_two_cycles: assert property ((lo | hi) |=> lookup_busy [*2] ##1 !lookup_busy)
    else $error("busy window wrong");
  a_high_step_ptr: assert property (hi |-> ##3 table_pointer == $past(table_pointer, 3) + 12'h001)
    else $error("pointer not advanced");
  a_low_hold_ptr: assert property (lo |-> ##3 table_pointer == $past(table_pointer, 3))
    else $error("pointer moved on low read");
  a_ram_addr_pair: assert property (ram_addr == {ram_pointer_pair_page, ram_pointer_pair_word})
    else $error("ram address split wrong");
  a_word_post_inc: assert property (inpage_op == 2'h2 |=>
    ram_pointer_pair_word == $past(ram_pointer_pair_word) + 4'h1)
    else $error("word step up wrong");
  a_word_post_dec: assert property (inpage_op == 2'h3 |=>
    ram_pointer_pair_word == $past(ram_pointer_pair_word) - 4'h1)
    else $error("word step down wrong");
  a_port_bit_sel: assert property (indirect_port_bit_op |=>
    port_bit_sel == 16'h0001 << $past(ram_pointer_pair_word))
    else $error("port bit select wrong");
endmodule // tlr_lookup_monitor

bind tlr_lookup tlr_lookup_monitor mon (.*);

// ### dv/tlr_tb.sv
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin fails++; \
  $display("FAIL %s exp %h got %h", n, e, a); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rst = 0, ptr_load = 0, ram_access = 0, rom_wr_en = 0;
  logic load_low_nibble_lookup = 0, load_high_nibble_lookup = 0, page_load = 0;
  logic indirect_port_bit_op = 0, acc_valid_q, lookup_busy, special_area_q, ram_access_done;
  logic [1:0] inpage_op = 0;
  logic [3:0] page_val = 0, inpage_val = 0, acc_data_q, s_acc;
  logic [3:0] ram_pointer_pair_page, ram_pointer_pair_word;
  logic [7:0] rom_wr_data = 0, ram_addr;
  logic [11:0] ptr_load_val = 0, rom_wr_addr = 0, table_pointer;
  logic [15:0] port_bit_sel;
  int fails = 0, n_tests = 0;
  tlr_lookup #(.LARGE_VARIANT(1)) dut (.*);
  // small variant shares every input; only its result is watched
  tlr_lookup #(.LARGE_VARIANT(0)) dut_s (.*, .acc_data_q(s_acc), .acc_valid_q(),
    .lookup_busy(), .table_pointer(), .special_area_q(), .ram_addr(), .ram_access_done(),
    .ram_pointer_pair_page(), .ram_pointer_pair_word(), .port_bit_sel());
  // clock
  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    {rom_wr_en, rom_wr_addr, rom_wr_data} = {1'b1, a, d};
    @(negedge clk_sys);
    rom_wr_en = 0;
  endtask
  task automatic setp(input logic [11:0] a);
    @(negedge clk_sys);
    {ptr_load, ptr_load_val} = {1'b1, a};
    @(negedge clk_sys);
    ptr_load = 0;
  endtask
  // ends in the cycle where the result pulse stands
  task automatic look(input logic h);
    @(negedge clk_sys);
    {load_low_nibble_lookup, load_high_nibble_lookup} = {~h, h};
    @(negedge clk_sys);
    {load_low_nibble_lookup, load_high_nibble_lookup} = 2'b00;
    @(negedge clk_sys);
  endtask
  task automatic t_lookup;
    wr(12'h086, 8'h5a);
    wr(12'h087, 8'hc3);
    setp(12'h086);
    look(0);
    `CHK("lo", 4'ha, acc_data_q)
    `CHK("vld", 1'b1, acc_valid_q)
    `CHK("spc", 1'b1, special_area_q)
    look(1);
    `CHK("hi", 4'h5, acc_data_q)
    `CHK("ptr", 12'h087, table_pointer)
    look(0);
    `CHK("lo2", 4'h3, acc_data_q)
    `CHK("spc2", 1'b0, special_area_q)
    $display("done lookup");
  endtask
  task automatic t_alias;
    wr(12'h8a5, 8'h3c);
    wr(12'h0a5, 8'h71);
    setp(12'h8a5);
    look(0);
    `CHK("big", 4'hc, acc_data_q)
    `CHK("small", 4'h1, s_acc)
    look(1);
    `CHK("small_hi", 4'h7, s_acc)
    `CHK("ptr12", 12'h8a6, table_pointer)
    $display("done alias");
  endtask
  task automatic t_ram;
    @(negedge clk_sys);
    {page_load, page_val, inpage_op, inpage_val} = {1'b1, 4'ha, 2'h1, 4'hf};
    ram_access = 1;
    @(negedge clk_sys);
    `CHK("acc_done", 1'b1, ram_access_done)
    ram_access = 0;
    {page_load, inpage_op} = {1'b0, 2'h2};
    @(negedge clk_sys);
    inpage_op = 2'h3;
    `CHK("addr", 8'ha0, ram_addr)
    `CHK("page", 4'ha, ram_pointer_pair_page)
    @(negedge clk_sys);
    {inpage_op, indirect_port_bit_op} = {2'h0, 1'b1};
    @(negedge clk_sys);
    indirect_port_bit_op = 0;
    `CHK("bit", 16'h8000, port_bit_sel)
    @(negedge clk_sys);
    `CHK("bit0", 16'h0000, port_bit_sel)
    $display("done ram");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // main sequence
  initial
  begin
    // a real rising edge so the asynchronous reset branch runs
    #5 rst = 1;
    repeat (12) @(negedge clk_sys);
    rst = 0;
    t_lookup();
    t_alias();
    t_ram();
    results();
  end
  // hang guard, well beyond the few dozen cycles needed
  initial
  begin
    #20000;
    fails++;
    results();
  end
endmodule // tb
